// ===== core/qsr_defs.svh
// constants for the doubtful result status and service request block
`ifndef QSR_DEFS_SVH
`define QSR_DEFS_SVH
`define QSR_NCH 2
`define QSR_NWIN 2
`define QSR_NLM 4
`define QSR_NI 8
`define QSR_SUB_W 16
`define QSR_STB_W 8
`define QSR_LM_USED 16'h00ff
`define QSR_OV_USED 16'h000f
`define QSR_TM_USED 16'h0002
`define QSR_OV_INPUT_BIT 3
`define QSR_TM_SHORT_BIT 1
`define QSR_STB_REQ_MASK 8'hbc
`define QSR_STB_ERRQ_BIT 2
`define QSR_STB_DOUBT_BIT 3
`define QSR_STB_OBUF_BIT 4
`define QSR_STB_ESB_BIT 5
`define QSR_STB_MSS_BIT 6
`define QSR_STB_OPER_BIT 7
`define QSR_PP_SENSE_BIT 8
`define QSR_RST_ENAB 16'h0000
`define QSR_RST_SRE 8'h00
`define QSR_RST_PPE 8'h00
`endif

// ===== core/qsr_pkg.sv
// types shared by the doubtful result status block
package qsr_pkg;
  typedef enum logic [2:0] {
    QSR_SEL_LM,
    QSR_SEL_OV,
    QSR_SEL_TM,
    QSR_SEL_SRE,
    QSR_SEL_PPE,
    QSR_SEL_STB,
    QSR_SEL_RECON,
    QSR_SEL_NONE
  } qsr_sel_e;
  typedef enum logic [1:0] {
    QSR_PART_COND,
    QSR_PART_EVENT,
    QSR_PART_ENAB,
    QSR_PART_NONE
  } qsr_part_e;
endpackage

// ===== core/qsr_status.sv
// doubtful result sub-registers, status byte, request and poll logic
`timescale 1ns/100ps
`include "qsr_defs.svh"
module qsr_status
  import qsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // measurement conditions, sampled each clock
  input wire logic [`QSR_NLM*8-1:0] limit_margin_fail,
  input wire logic [`QSR_NCH-1:0] rf_overload,
  input wire logic [`QSR_NCH-1:0] rf_underload,
  input wire logic [`QSR_NCH-1:0] if_overload,
  input wire logic [`QSR_NCH-1:0] input_overload,
  input wire logic [`QSR_NCH-1:0] sweep_too_short,
  // other status byte sources
  input wire logic err_queue_nonempty,
  input wire logic out_buf_avail,
  input wire logic event_status_sum,
  input wire logic oper_sum,
  // query port
  input wire logic query_req,
  input wire logic [2:0] query_sel,
  input wire logic [1:0] query_part,
  input wire logic query_chan,
  input wire logic query_win,
  output logic query_valid_q,
  output logic [`QSR_SUB_W-1:0] query_data_q,
  // setting port
  input wire logic set_req,
  input wire logic [2:0] set_sel,
  input wire logic set_chan,
  input wire logic set_win,
  input wire logic [`QSR_SUB_W-1:0] set_data,
  // results towards the controller and front end
  output logic srq_q,
  output logic pp_resp_q,
  output logic [`QSR_STB_W-1:0] stb_q,
  output logic [`QSR_NCH-1:0] rf_connect_q
);

  ////////////////////////////////////////////////////////////////////////
  // instance addressing: limit margin per channel and window, then
  // overload per channel, then timing per channel
  localparam int NI = `QSR_NI;
  logic [2:0] q_idx, s_idx;
  logic [2:0] q_base, s_base;
  assign q_base = (query_sel == QSR_SEL_OV) ? 3'h4 :
                  (query_sel == QSR_SEL_TM) ? 3'h6 : 3'h0;
  assign s_base = (set_sel == QSR_SEL_OV) ? 3'h4 :
                  (set_sel == QSR_SEL_TM) ? 3'h6 : 3'h0;
  assign q_idx = (query_sel == QSR_SEL_LM) ?
                 {1'b0, query_chan, query_win} :
                 q_base + {2'h0, query_chan};
  assign s_idx = (set_sel == QSR_SEL_LM) ?
                 {1'b0, set_chan, set_win} :
                 s_base + {2'h0, set_chan};
  logic q_sub, s_sub;
  assign q_sub = query_sel == QSR_SEL_LM || query_sel == QSR_SEL_OV ||
                 query_sel == QSR_SEL_TM;
  assign s_sub = set_sel == QSR_SEL_LM || set_sel == QSR_SEL_OV ||
                 set_sel == QSR_SEL_TM;

  ////////////////////////////////////////////////////////////////////////
  // raw condition vectors, bit 15 and unused bits forced low
  logic [`QSR_SUB_W-1:0] raw [NI];
  logic [`QSR_SUB_W-1:0] used [NI];
  logic [`QSR_SUB_W-1:0] cond_q [NI];
  logic [`QSR_SUB_W-1:0] event_q [NI];
  logic [`QSR_SUB_W-1:0] enab_q [NI];
  logic [NI-1:0] sub_sum;

  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++) begin : g_inst
      logic [`QSR_SUB_W-1:0] cond_d, event_d, enab_d;
      logic rd_clr, wr_en;
      if (gi < `QSR_NLM) begin : g_lm
        assign raw[gi] = {8'h00, limit_margin_fail[gi*8 +: 8]};
        assign used[gi] = `QSR_LM_USED;
      end else if (gi < `QSR_NLM + `QSR_NCH) begin : g_ov
        localparam int C = gi - `QSR_NLM;
        assign raw[gi] = {12'h000, input_overload[C],
                          if_overload[C],
                          rf_underload[C],
                          rf_overload[C]};
        assign used[gi] = `QSR_OV_USED;
      end else begin : g_tm
        localparam int C = gi - `QSR_NLM - `QSR_NCH;
        assign raw[gi] = {14'h0000, sweep_too_short[C], 1'b0};
        assign used[gi] = `QSR_TM_USED;
      end
      // unused bits and bit 15 never store anything
      assign cond_d = raw[gi] & used[gi];
      assign rd_clr = query_req && q_sub && q_idx == 3'(gi) &&
                      query_part == QSR_PART_EVENT;
      // a rising condition in the read cycle survives the clear
      assign event_d = (event_q[gi] & {`QSR_SUB_W{~rd_clr}}) |
                       (cond_d & ~cond_q[gi]);
      assign wr_en = set_req && s_sub && s_idx == 3'(gi);
      assign enab_d = wr_en ? (set_data & used[gi]) : enab_q[gi];
      assign sub_sum[gi] = |(event_q[gi] & enab_q[gi]);
      always_ff @(posedge clk) begin
        if (rst) begin
          cond_q[gi] <= '0;
          event_q[gi] <= '0;
          enab_q[gi] <= `QSR_RST_ENAB;
        end else begin
          cond_q[gi] <= cond_d;
          event_q[gi] <= event_d;
          enab_q[gi] <= enab_d;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // status byte, request and parallel poll
  logic [`QSR_STB_W-1:0] sre_q, ppe_q, stb_d, stb_base;
  logic pp_sense_q, mss, pp_d;
  assign stb_base = {oper_sum, 1'b0, event_status_sum, out_buf_avail,
                     |sub_sum, err_queue_nonempty, 2'b00};
  assign mss = |(stb_base & sre_q & `QSR_STB_REQ_MASK);
  assign stb_d = stb_base | ({7'h00, mss} << `QSR_STB_MSS_BIT);
  // bit 6 takes part in the poll as well
  assign pp_d = (|(stb_d & ppe_q)) ^ pp_sense_q;

  // enable masks for the status byte; sense rides in the poll write
  always_ff @(posedge clk) begin
    if (rst) begin
      sre_q <= `QSR_RST_SRE;
      ppe_q <= `QSR_RST_PPE;
      pp_sense_q <= 1'b0;
    end else if (set_req && set_sel == QSR_SEL_SRE) begin
      sre_q <= set_data[`QSR_STB_W-1:0];
    end else if (set_req && set_sel == QSR_SEL_PPE) begin
      ppe_q <= set_data[`QSR_STB_W-1:0];
      pp_sense_q <= set_data[`QSR_PP_SENSE_BIT];
    end
  end

  // registered outputs keep the pins glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      stb_q <= '0;
      srq_q <= 1'b0;
      pp_resp_q <= 1'b0;
    end else begin
      stb_q <= stb_d;
      srq_q <= mss;
      pp_resp_q <= pp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input protection: once tripped, only reset or an explicit reconnect with the
  // level back in range restores the path; a reconnect while still
  // overloaded is ignored
  genvar gc;
  generate
    for (gc = 0; gc < `QSR_NCH; gc++) begin : g_prot
      logic recon;
      assign recon = set_req && set_sel == QSR_SEL_RECON &&
                     set_chan == 1'(gc) && !input_overload[gc];
      always_ff @(posedge clk) begin
        if (rst) begin
          rf_connect_q[gc] <= 1'b1;
        end else if (input_overload[gc]) begin
          rf_connect_q[gc] <= 1'b0;
        end else if (recon) begin
          rf_connect_q[gc] <= 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // query answer one clock after the request; unmapped reads give zero
  logic [`QSR_SUB_W-1:0] sub_word, q_word;
  assign sub_word = (query_part == QSR_PART_COND) ? cond_q[q_idx] :
                    (query_part == QSR_PART_EVENT) ? event_q[q_idx] :
                    (query_part == QSR_PART_ENAB) ? enab_q[q_idx] : '0;
  assign q_word = q_sub ? sub_word :
                  (query_sel == QSR_SEL_SRE) ? {8'h00, sre_q} :
                  (query_sel == QSR_SEL_PPE) ? {8'h00, ppe_q} :
                  (query_sel == QSR_SEL_STB) ? {8'h00, stb_q} : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      query_valid_q <= 1'b0;
      query_data_q <= '0;
    end else begin
      query_valid_q <= query_req;
      query_data_q <= query_req ? q_word : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_lm_bit;
    @(posedge clk) disable iff (rst)
    limit_margin_fail[0] |=> cond_q[0][0];
  endproperty
  a_lm_bit: assert property (p_lm_bit) else $error("lm cond lost");

  property p_bit15;
    @(posedge clk) disable iff (rst)
    !cond_q[4][15] && !event_q[2][15] && !enab_q[6][0];
  endproperty
  a_bit15: assert property (p_bit15) else $error("inert bit set");

  property p_event_rise;
    @(posedge clk) disable iff (rst)
    $rose(cond_q[1][3]) |-> event_q[1][3] ##0 1'b1 or
    (event_q[1][3] == 1'b1);
  endproperty
  a_event_rise: assert property (p_event_rise) else $error("no latch");

  property p_read_clear;
    @(posedge clk) disable iff (rst)
    (query_req && query_sel == QSR_SEL_OV && query_part == QSR_PART_EVENT
     && !query_chan && cond_q[4] == '0 && raw[4] == '0) |=> event_q[4] == '0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("no clear");

  property p_ovl_disc;
    @(posedge clk) disable iff (rst)
    input_overload[0] |=> !rf_connect_q[0] ##1 (!rf_connect_q[0] ||
      $past(set_req) && $past(set_sel) == QSR_SEL_RECON);
  endproperty
  a_ovl_disc: assert property (p_ovl_disc) else $error("not cut");

  property p_srq;
    @(posedge clk) disable iff (rst)
    (|(stb_base & sre_q & `QSR_STB_REQ_MASK)) |=> srq_q && stb_q[6];
  endproperty
  a_srq: assert property (p_srq) else $error("srq missing");

  property p_srq_only;
    @(posedge clk) disable iff (rst)
    srq_q |->
      ($past(stb_base) & $past(sre_q) & `QSR_STB_REQ_MASK) != 8'h00;
  endproperty
  a_srq_only: assert property (p_srq_only) else $error("stray srq");

  property p_doubt_sum;
    @(posedge clk) disable iff (rst)
    (|(event_q[7] & enab_q[7])) |=> stb_q[`QSR_STB_DOUBT_BIT];
  endproperty
  a_doubt_sum: assert property (p_doubt_sum) else $error("no sum");

  property p_pp;
    @(posedge clk) disable iff (rst)
    1'b1 |=> pp_resp_q == ((|($past(stb_d) & $past(ppe_q))) ^
                           $past(pp_sense_q));
  endproperty
  a_pp: assert property (p_pp) else $error("poll wrong");

  property p_answer;
    @(posedge clk) disable iff (rst)
    query_req |=> query_valid_q ##1 !query_valid_q || $past(query_req);
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");

  property p_rf_ov;
    @(posedge clk) disable iff (rst)
    rf_overload[0] |=> cond_q[4][0];
  endproperty
  a_rf_ov: assert property (p_rf_ov) else $error("rf ovld lost");

  property p_underload;
    @(posedge clk) disable iff (rst)
    rf_underload[0] |=> cond_q[4][1];
  endproperty
  a_underload: assert property (p_underload) else $error("unld lost");

  property p_if_ov;
    @(posedge clk) disable iff (rst)
    if_overload[0] |=> cond_q[4][2];
  endproperty
  a_if_ov: assert property (p_if_ov) else $error("if ovld lost");

  property p_in_ov;
    @(posedge clk) disable iff (rst)
    input_overload[0] |=> cond_q[4][3];
  endproperty
  a_in_ov: assert property (p_in_ov) else $error("input ovld lost");

  // a wrong channel map would leak channel 0 into channel 1
  property p_ov_sep;
    @(posedge clk) disable iff (rst)
    !rf_overload[1] |=> !cond_q[5][0];
  endproperty
  a_ov_sep: assert property (p_ov_sep) else $error("chan leak");

  property p_short;
    @(posedge clk) disable iff (rst)
    sweep_too_short[1] |=> cond_q[7][1] && !cond_q[7][0];
  endproperty
  a_short: assert property (p_short) else $error("short lost");

  property p_reconnect;
    @(posedge clk) disable iff (rst)
    (set_req && set_sel == QSR_SEL_RECON && !set_chan &&
     !input_overload[0]) |=> rf_connect_q[0];
  endproperty
  a_reconnect: assert property (p_reconnect) else $error("no recon");

  c_srq: cover property (@(posedge clk) disable iff (rst) $rose(srq_q));
  c_disc: cover property (@(posedge clk) disable iff (rst)
    $fell(rf_connect_q[0]) ##[1:20] rf_connect_q[0]);
  c_clear: cover property (@(posedge clk) disable iff (rst)
    event_q[0] != '0 ##1 event_q[0] == '0);
  c_pp: cover property (@(posedge clk) disable iff (rst) $rose(pp_resp_q));
  c_short: cover property (@(posedge clk) disable iff (rst)
    $rose(event_q[7][1]));
endmodule

// ===== tb/qsr_ctl_model.sv
// remote controller model that queries and programs the status block
`timescale 1ns/100ps
`include "qsr_defs.svh"
module qsr_ctl_model (
  // clock
  input wire logic clk,
  // query port
  output logic query_req,
  output logic [2:0] query_sel,
  output logic [1:0] query_part,
  output logic query_chan,
  output logic query_win,
  input wire logic query_valid_q,
  input wire logic [`QSR_SUB_W-1:0] query_data_q,
  // setting port
  output logic set_req,
  output logic [2:0] set_sel,
  output logic set_chan,
  output logic set_win,
  output logic [`QSR_SUB_W-1:0] set_data
);
  // idle request lines from time zero
  initial begin
    {query_req, query_sel, query_part, query_chan, query_win} = '0;
    {set_req, set_sel, set_chan, set_win, set_data} = '0;
  end
  // one-cycle query, answer taken the cycle after the request edge
  task automatic query(input logic [2:0] sel, input logic [1:0] part,
    input logic ch, input logic win, output logic [15:0] data,
    output logic ok);
    @(posedge clk);
    #1;
    {query_req, query_sel, query_part, query_chan, query_win} =
      {1'b1, sel, part, ch, win};
    @(posedge clk);
    #1;
    ok = query_valid_q;
    data = query_data_q;
    query_req = 1'b0;
  endtask
  // one-cycle setting write, no answer
  task automatic write(input logic [2:0] sel, input logic ch,
    input logic win, input logic [15:0] data);
    @(posedge clk);
    #1;
    {set_req, set_sel, set_chan, set_win, set_data} =
      {1'b1, sel, ch, win, data};
    @(posedge clk);
    #1;
    set_req = 1'b0;
  endtask
  // every request enable bit set to one
  task automatic enable_all();
    write(3'h3, 1'b0, 1'b0, 16'h00ff);
  endtask
  // status byte read after a request to find the cause
  task automatic serial_poll(output logic [15:0] data);
    logic ok;
    query(3'h5, 2'h0, 1'b0, 1'b0, data, ok);
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the status and service request block
`timescale 1ns/100ps
`include "qsr_defs.svh"
module tb_top;
  import qsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] lm_fail = '0;
  logic [1:0] rf_ov = '0, rf_un = '0, if_ov = '0, in_ov = '0, short = '0;
  logic [3:0] src = '0;
  logic q_req, q_ch, q_win, q_val, s_req, s_ch, s_win, srq, pp;
  logic [2:0] q_sel, s_sel;
  logic [1:0] q_part, conn;
  logic [15:0] q_data, s_data, rd_v;
  logic [7:0] stb;
  int pos [4] = '{2, 4, 5, 7};
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  qsr_status i_dut (.clk(clk), .rst(rst), .limit_margin_fail(lm_fail),
    .rf_overload(rf_ov), .rf_underload(rf_un), .if_overload(if_ov),
    .input_overload(in_ov), .sweep_too_short(short),
    .err_queue_nonempty(src[0]), .out_buf_avail(src[1]),
    .event_status_sum(src[2]), .oper_sum(src[3]), .query_req(q_req),
    .query_sel(q_sel), .query_part(q_part), .query_chan(q_ch),
    .query_win(q_win), .query_valid_q(q_val), .query_data_q(q_data),
    .set_req(s_req), .set_sel(s_sel), .set_chan(s_ch), .set_win(s_win),
    .set_data(s_data), .srq_q(srq), .pp_resp_q(pp), .stb_q(stb),
    .rf_connect_q(conn));
  qsr_ctl_model i_ctl (.clk(clk), .query_req(q_req), .query_sel(q_sel),
    .query_part(q_part), .query_chan(q_ch), .query_win(q_win),
    .query_valid_q(q_val), .query_data_q(q_data), .set_req(s_req),
    .set_sel(s_sel), .set_chan(s_ch), .set_win(s_win), .set_data(s_data));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // inputs always change one step after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] sel, input logic [1:0] part,
    input logic ch, input logic win);
    logic ok;
    i_ctl.query(sel, part, ch, win, rd_v, ok);
    chk("query valid", {15'h0, ok}, 16'h0001);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(5);
    rst = 1'b0;
    chk("stb reset", {8'h0, stb}, 16'h0000);
    chk("connect reset", {14'h0, conn}, 16'h0003);
    $display("test reset done");
    // margins 1 and 8 fail on channel 1 window 1
    lm_fail[31:24] = 8'h81;
    tick(3);
    rd(3'h0, 2'h0, 1'b1, 1'b1);
    chk("lm cond", rd_v, 16'h0081);
    rd(3'h0, 2'h1, 1'b1, 1'b1);
    chk("lm event", rd_v, 16'h0081);
    rd(3'h0, 2'h1, 1'b1, 1'b1);
    chk("lm event cleared", rd_v, 16'h0000);
    rd(3'h0, 2'h0, 1'b1, 1'b0);
    chk("lm other window", rd_v, 16'h0000);
    $display("test limit margin done");
    // one overload cause at a time on channel 0
    for (int b = 0; b < 4; b++) begin
      {in_ov[0], if_ov[0], rf_un[0], rf_ov[0]} = 4'h1 << b;
      tick(3);
      rd(3'h1, 2'h0, 1'b0, 1'b0);
      chk("ov cond", rd_v, 16'h0001 << b);
    end
    rd(3'h1, 2'h0, 1'b1, 1'b0);
    chk("ov other chan", rd_v, 16'h0000);
    chk("input cut", {14'h0, conn}, 16'h0002);
    i_ctl.write(3'h6, 1'b0, 1'b0, 16'h0000);
    tick(2);
    chk("reconnect refused", {14'h0, conn}, 16'h0002);
    in_ov[0] = 1'b0;
    tick(2);
    i_ctl.write(3'h6, 1'b0, 1'b0, 16'h0000);
    tick(2);
    chk("reconnect", {14'h0, conn}, 16'h0003);
    rd(3'h1, 2'h1, 1'b0, 1'b0);
    chk("ov event", rd_v, 16'h000f);
    rd(3'h1, 2'h1, 1'b0, 1'b0);
    chk("ov event cleared", rd_v, 16'h0000);
    short = 2'b10;
    tick(3);
    rd(3'h2, 2'h0, 1'b1, 1'b0);
    chk("tm cond", rd_v, 16'h0002);
    i_ctl.write(3'h2, 1'b1, 1'b0, 16'hffff);
    tick(2);
    chk("tm summary", {8'h0, stb}, 16'h0008);
    rd(3'h2, 2'h2, 1'b1, 1'b0);
    chk("tm enable", rd_v, 16'h0002);
    rd(3'h2, 2'h1, 1'b1, 1'b0);
    chk("tm event", rd_v, 16'h0002);
    tick(2);
    chk("tm summary cleared", {8'h0, stb}, 16'h0000);
    $display("test overload and timing done");
    // enabled margin event rises up to a request
    i_ctl.write(3'h0, 1'b1, 1'b1, 16'hffff);
    rd(3'h0, 2'h2, 1'b1, 1'b1);
    chk("lm enable", rd_v, 16'h00ff);
    lm_fail[31:24] = 8'h00;
    tick(3);
    lm_fail[31:24] = 8'h02;
    tick(5);
    chk("stb summary", {8'h0, stb}, 16'h0008);
    chk("request masked", {15'h0, srq}, 16'h0000);
    i_ctl.enable_all();
    tick(3);
    chk("request", {15'h0, srq}, 16'h0001);
    rd(3'h3, 2'h0, 1'b0, 1'b0);
    chk("sre readback", rd_v, 16'h00ff);
    i_ctl.serial_poll(rd_v);
    chk("serial poll", rd_v, 16'h0048);
    rd(3'h0, 2'h1, 1'b1, 1'b1);
    chk("lm event second", rd_v, 16'h0002);
    tick(4);
    chk("summary cleared", {8'h0, stb}, 16'h0000);
    // each other source bit of the status byte
    for (int k = 0; k < 4; k++) begin
      src = 4'h1 << k;
      tick(4);
      chk("stb source", {8'h0, stb}, 16'h0040 | (16'h1 << pos[k]));
      chk("source request", {15'h0, srq}, 16'h0001);
    end
    src = 4'h1;
    i_ctl.write(3'h4, 1'b0, 1'b0, 16'h0040);
    tick(3);
    chk("poll bit", {15'h0, pp}, 16'h0001);
    i_ctl.write(3'h4, 1'b0, 1'b0, 16'h0140);
    tick(3);
    chk("poll inverted", {15'h0, pp}, 16'h0000);
    rd(3'h4, 2'h0, 1'b0, 1'b0);
    chk("ppe readback", rd_v, 16'h0040);
    src = 4'h0;
    tick(4);
    chk("request gone", {15'h0, srq}, 16'h0000);
    $display("test request and poll done");
    give_verdict();
  end
endmodule
